// ===== spd_pkg.sv
/*
 Shared constants and types for the register page decoder.
 Assumes a single core clock domain and a direct-address access bus from the core.
*/
package spd_pkg;
	localparam logic [7:0] SPD_ADDR_PAGE_SEL = 8'hA7;
	localparam logic [7:0] SPD_ADDR_CONV_ACC = 8'hBA;
	localparam logic [7:0] SPD_ADDR_IREF = 8'hB9;
	localparam logic [7:0] SPD_ADDR_P0 = 8'hA4;
	localparam logic [7:0] SPD_ADDR_DCDC = 8'h97;
	localparam logic [7:0] SPD_ADDR_EXT_INT_EN = 8'hE6;
	localparam logic [7:0] SPD_SFR_BASE = 8'h80;
	localparam logic [7:0] SPD_PAGE_ZERO = 8'h00;
	localparam logic [7:0] SPD_PAGE_HIGH = 8'h0F;
	localparam logic [7:0] SPD_PAGE_RESET = 8'h00;
	localparam logic [2:0] SPD_BIT_LOW_MASK = 3'h0;

	typedef enum logic [3:0] {
		SPD_SEL_NONE,
		SPD_SEL_PAGE_SELECT,
		SPD_SEL_CONV_ACC_CFG,
		SPD_SEL_CONV_BURST_PWR,
		SPD_SEL_IREF_CTRL,
		SPD_SEL_IREF_CFG,
		SPD_SEL_P0_OUT_MODE,
		SPD_SEL_P0_DRIVE,
		SPD_SEL_DCDC_CTRL,
		SPD_SEL_CRC_SECT_CNT,
		SPD_SEL_EXT_INT_EN
	} spd_sel_t;

	typedef struct packed {
		logic valid;
		logic direct;
		logic rd;
		logic wr;
		logic bit_op;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spd_req_t;

	typedef struct packed {
		logic valid;
		logic wr;
		logic rd;
		spd_sel_t sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spd_route_t;
endpackage : spd_pkg

// ===== spd_page_decoder.sv
/*
 Page select register and address decoder for the special register space.
 Assumes the core presents one access per cycle on the same clock and reads
 peripheral data back through its own mux, using the selection reported here.
*/
`timescale 1ns/1ns
module spd_page_decoder
	import spd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Core access
	input spd_req_t req,
	// Routed access to peripherals
	output spd_route_t route,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic bit_refused,
	// Current page
	output logic [7:0] page_sel
);

	// Page select register
	logic [7:0] page_r;
	logic [7:0] page_nxt;

	// Strobe handed on to the selected peripheral register
	spd_route_t route_r;
	spd_route_t route_nxt;

	// Read return for the page register and for unmapped holes
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;

	// Refused single-bit access
	logic refused_r;
	logic refused_nxt;

	// Decode of the access presented this cycle
	spd_sel_t sel;
	logic in_space;
	logic bit_ok;
	logic go;
	logic mapped;
	logic unmapped;
	logic hits_page_reg;

	// Direct mode with the top address bit set, so 0x80..0xFF;
	// indirect data accesses to the same range never get here
	function automatic logic spd_in_sfr_space(input spd_req_t r);
		return r.valid && r.direct && r.addr[7];
	endfunction : spd_in_sfr_space

	// Bit access only where the low three address bits are clear
	function automatic logic spd_bit_allowed(input spd_req_t r);
		return !r.bit_op || (r.addr[2:0] == SPD_BIT_LOW_MASK);
	endfunction : spd_bit_allowed

	// Registers that answer on every page, the page register among them
	function automatic spd_sel_t spd_all_page_decode(input logic [7:0] a);
		spd_sel_t s;
		s = SPD_SEL_NONE;
		if (a == SPD_ADDR_PAGE_SEL)
			s = SPD_SEL_PAGE_SELECT;
		else if (a == SPD_ADDR_EXT_INT_EN)
			s = SPD_SEL_EXT_INT_EN;
		return s;
	endfunction : spd_all_page_decode

	// Registers seen only while the default page is selected
	function automatic spd_sel_t spd_low_page_decode(input logic [7:0] a);
		spd_sel_t s;
		unique case (a)
			SPD_ADDR_CONV_ACC: s = SPD_SEL_CONV_ACC_CFG;
			SPD_ADDR_IREF: s = SPD_SEL_IREF_CTRL;
			SPD_ADDR_P0: s = SPD_SEL_P0_OUT_MODE;
			SPD_ADDR_DCDC: s = SPD_SEL_DCDC_CTRL;
			default: s = SPD_SEL_NONE;
		endcase
		return s;
	endfunction : spd_low_page_decode

	// Registers seen only while the high page is selected
	function automatic spd_sel_t spd_high_page_decode(input logic [7:0] a);
		spd_sel_t s;
		unique case (a)
			SPD_ADDR_CONV_ACC: s = SPD_SEL_CONV_BURST_PWR;
			SPD_ADDR_IREF: s = SPD_SEL_IREF_CFG;
			SPD_ADDR_P0: s = SPD_SEL_P0_DRIVE;
			SPD_ADDR_DCDC: s = SPD_SEL_CRC_SECT_CNT;
			default: s = SPD_SEL_NONE;
		endcase
		return s;
	endfunction : spd_high_page_decode

	// All-page registers are matched first, so no page value can hide them
	function automatic spd_sel_t spd_decode(input logic [7:0] a,
		input logic [7:0] pg);
		spd_sel_t s;
		s = spd_all_page_decode(a);
		if (s == SPD_SEL_NONE)
		begin
			if (pg == SPD_PAGE_ZERO)
				s = spd_low_page_decode(a);
			else if (pg == SPD_PAGE_HIGH)
				s = spd_high_page_decode(a);
		end
		return s;
	endfunction : spd_decode

	assign in_space = spd_in_sfr_space(req);
	assign bit_ok = spd_bit_allowed(req);
	assign go = in_space && bit_ok;
	assign sel = spd_decode(req.addr, page_r);
	assign mapped = go && (sel != SPD_SEL_NONE);
	assign unmapped = go && (sel == SPD_SEL_NONE);
	assign hits_page_reg = go && (sel == SPD_SEL_PAGE_SELECT);

	// A modify carries rd and wr together; its read sees the old page,
	// and the new page only steers the access after it
	always_comb
	begin
		page_nxt = page_r;
		if (hits_page_reg && req.wr)
			page_nxt = req.wdata;
	end

	// Reset puts every access back on the default page
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			page_r <= SPD_PAGE_RESET;
		else
			page_r <= page_nxt;
	end

	// Unmapped and refused accesses send no strobe, so nothing is disturbed
	always_comb
	begin
		route_nxt = '0;
		if (mapped)
		begin
			route_nxt.valid = 1'b1;
			route_nxt.rd = req.rd;
			route_nxt.wr = req.wr;
			route_nxt.sel = sel;
			route_nxt.addr = req.addr;
			route_nxt.wdata = req.wdata;
		end
	end

	// One-cycle strobe; the peripheral must act on it in that cycle
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			route_r <= '0;
		else
			route_r <= route_nxt;
	end

	// A hole reads as zero so the core still gets an answer in one cycle;
	// software must not rely on that value
	always_comb
	begin
		rdata_nxt = '0;
		rvalid_nxt = 1'b0;
		if (hits_page_reg && req.rd)
		begin
			rdata_nxt = page_r;
			rvalid_nxt = 1'b1;
		end
		else if (unmapped && req.rd)
			rvalid_nxt = 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// A refused bit access writes nothing anywhere; the core sees the flag
	// and may repeat the access as a whole byte
	always_comb
	begin
		refused_nxt = in_space && !bit_ok;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			refused_r <= 1'b0;
		else
			refused_r <= refused_nxt;
	end

	// Every output comes straight from its register
	assign route = route_r;
	assign rdata = rdata_r;
	assign rdata_valid = rvalid_r;
	assign bit_refused = refused_r;
	assign page_sel = page_r;

endmodule : spd_page_decoder

// ===== spd_assertions.sv
/* Port checker for the page decoder.
 Bound to every spd_page_decoder instance. */
`timescale 1ns/1ns
module spd_assertions
	import spd_pkg::*;
(
	// Watched ports
	input wire logic ref_clk,
	input wire logic resetn,
	input spd_req_t req,
	input spd_route_t route,
	input logic [7:0] rdata,
	input logic rdata_valid,
	input logic bit_refused,
	input logic [7:0] page_sel
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire tk = req.valid && req.direct && req.addr[7];
	sequence at(a);
		tk && !req.bit_op && req.addr == a;
	endsequence
	chk_page_write: assert property (at(8'hA7) ##0 req.wr
		|=> page_sel == $past(req.wdata)) else $error("page");
	chk_burst_sel: assert property (at(8'hBA) ##0 page_sel == 8'h0F
		|=> route.sel == SPD_SEL_CONV_BURST_PWR) else $error("BA");
	chk_iref_sel: assert property (at(8'hB9) ##0 page_sel == 8'h00
		|=> route.sel == SPD_SEL_IREF_CTRL) else $error("B9");
	chk_port_sel: assert property (at(8'hA4) ##0 page_sel == 8'h0F
		|=> route.sel == SPD_SEL_P0_DRIVE) else $error("A4");
	chk_dcdc_sel: assert property (at(8'h97) ##0 page_sel == 8'h00
		|=> route.sel == SPD_SEL_DCDC_CTRL) else $error("97");
	chk_all_page: assert property (at(8'hE6)
		|=> route.valid && route.sel == SPD_SEL_EXT_INT_EN) else $error("E6");
	chk_page_read: assert property (at(8'hA7) ##0 req.rd
		|=> rdata_valid && rdata == $past(page_sel)) else $error("A7 read");
	chk_page_hold: assert property (!(tk && !req.bit_op
		&& req.addr == 8'hA7 && req.wr) |=> $stable(page_sel))
		else $error("page moved");
	chk_not_taken: assert property (!tk
		|=> !route.valid && !rdata_valid) else $error("taken");
	chk_bit_refuse: assert property (tk && req.bit_op
		&& req.addr[2:0] != 3'h0 |=> bit_refused && !route.valid)
		else $error("bit");
	chk_unmapped_read: assert property (at(8'h90) ##0 req.rd
		|=> rdata_valid && rdata == 8'h00 && !route.valid) else $error("90");
endmodule : spd_assertions
bind spd_page_decoder spd_assertions i_spd_assertions (.ref_clk(ref_clk),
	.resetn(resetn), .req(req), .route(route), .rdata(rdata),
	.rdata_valid(rdata_valid), .bit_refused(bit_refused), .page_sel(page_sel));

// ===== spd_core_model.sv
/* Core side model issuing direct accesses.
 Assumes one call per clock from the bench. */
`timescale 1ns/1ns
module spd_core_model
	import spd_pkg::*;
(
	// Clock and request
	input wire logic ref_clk,
	output spd_req_t req
);
	initial req = '0;
	// Held until the next call, so accesses can run back to back
	task go(input spd_req_t r);
		@(posedge ref_clk);
		req <= r;
	endtask : go
endmodule : spd_core_model

// ===== tb_top.sv
/* Self-checking bench for the page decoder.
 Assumes the core model is the only requester. */
`timescale 1ns/1ns
module tb_top
	import spd_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	spd_req_t req;
	spd_route_t route;
	logic [7:0] rdata, page_sel;
	logic rdata_valid, bit_refused;
	int bad_count = 0, n_compared = 0, cyc = 0;
	logic [7:0] adr [5] = '{8'hBA, 8'hB9, 8'hA4, 8'h97, 8'hE6};
	always #50 ref_clk = ~ref_clk;
	spd_core_model i_spd_core_model (.ref_clk(ref_clk), .req(req));
	spd_page_decoder i_spd_page_decoder (.ref_clk(ref_clk), .resetn(resetn),
		.req(req), .route(route), .rdata(rdata), .rdata_valid(rdata_valid),
		.bit_refused(bit_refused), .page_sel(page_sel));
	// Flags are rd, wr, bit access from the top bit down
	function automatic spd_req_t mk(logic [2:0] f, logic [7:0] a, d);
		return '{1'b1, 1'b1, f[2], f[1], f[0], a, d};
	endfunction : mk
	task automatic ex(spd_req_t r, logic [14:0] e, logic [7:0] pg);
		logic [14:0] g;
		logic [17:0] rt;
		logic [17:0] rx;
		i_spd_core_model.go(r);
		i_spd_core_model.go('0);
		#1;
		g = {route.valid, route.sel, rdata_valid, bit_refused, rdata};
		rt = {route.rd, route.wr, route.addr, route.wdata};
		rx = e[14] ? {r.rd, r.wr, r.addr, r.wdata} : 18'h00000;
		n_compared += 3;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %0t %h %h", $time, g, e);
		end
		if (page_sel !== pg)
		begin
			bad_count++;
			$display("unexpected %0t %h %h", $time, page_sel, pg);
		end
		// A routed strobe carries the access unchanged
		if (rt !== rx)
		begin
			bad_count++;
			$display("unexpected %0t %h %h", $time, rt, rx);
		end
	endtask : ex
	task automatic t_pages;
		logic [3:0] s;
		logic [7:0] pg;
		ex(mk(3'h4, 8'hA7, 8'h00), {5'h11, 2'h2, 8'h00}, 8'h00);
		for (int p = 1; p >= 0; p--)
		begin
			pg = p ? 8'h0F : 8'h00;
			i_spd_core_model.go(mk(3'h2, 8'hA7, pg));
			for (int i = 0; i < 5; i++)
			begin
				s = 4'(i < 4 ? 2 + 2 * i + p : 10);
				ex(mk(3'h4, adr[i], 8'h00), {1'b1, s, 10'h000}, pg);
			end
		end
	endtask : t_pages
	// Refused and ignored writes must leave the page alone
	task automatic t_refuse;
		ex(mk(3'h3, 8'hA7, 8'h0F), 15'h0100, 8'h00);
		ex(mk(3'h5, 8'h90, 8'h00), 15'h0200, 8'h00);
		ex(mk(3'h2, 8'h27, 8'h0F), 15'h0000, 8'h00);
		ex('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'hA7, 8'h0F}, 15'h0000, 8'h00);
		ex(mk(3'h4, 8'h90, 8'h00), 15'h0200, 8'h00);
		ex(mk(3'h6, 8'hA7, 8'h0F), {5'h11, 2'h2, 8'h00}, 8'h0F);
	endtask : t_refuse
	task final_report;
		if (bad_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 200)
		begin
			bad_count++;
			final_report();
		end
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		t_pages();
		t_refuse();
		final_report();
	end
endmodule : tb_top
